// ===== dv/shorc_motor_model.sv
// Motor and built-in encoder model for the orientation bench.
// Assumes the speed command is in r/min and the clock is 10 MHz.
module shorc_motor_model
(
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [10:0] speed_cmd_in,
    output logic      [10:0] motor_speed_out,
    output logic      [11:0] enc_pos_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] step;

    // Crawl one address a cycle at low speed so small zones are reachable
    assign step = (motor_speed_out >= 11'h010) ?
                  {4'h0, motor_speed_out[10:3]} :
                  {11'h000, motor_speed_out != 11'h000};

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            motor_speed_out <= 11'h000;
            enc_pos_out     <= 12'h123;
        end else begin
            motor_speed_out <= speed_cmd_in;
            enc_pos_out     <= enc_pos_out + step;
        end
    end
endmodule

// ===== dv/shorc_tb_top.sv
// Self-checking bench for the shaft orientation sequencer.
// Assumes the motor model closes the speed and encoder loop.
module shorc_tb_top
    import shorc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [13:0] SRCS [7] = '{SRC_SEL_EXT12, SRC_SEL_EXT6,
        SRC_SEL_EXT6, SRC_SEL_EXT12, SRC_SEL_EXT16, SRC_SEL_EXT12,
        SRC_SEL_EXT16};
    localparam logic [6:0] DIVS [7] = '{7'h05, 7'h00, 7'h01, 7'h01,
        7'h01, 7'h59, 7'h13};
    logic        sys_clk_in;
    logic        sys_rst_in;
    logic        start;
    logic        req;
    logic [7:0]  in_code;
    logic [7:0]  out_code;
    shorc_cfg_t  cfg;
    logic        ext_opt;
    logic [15:0] ext_pos;
    logic [11:0] enc_pos;
    logic [10:0] mspeed;
    logic [10:0] run_cmd;
    logic [10:0] speed_cmd;
    logic        lock;
    logic        active;
    logic        done_n;
    logic [12:0] pos_err;
    shorc_gain_t gains;
    int          err_total;
    int          compares;
    int          seed;

    shorc_top DUT (
        .sys_clk_in        (sys_clk_in),
        .sys_rst_in        (sys_rst_in),
        .start_in          (start),
        .orient_request_in (req),
        .in_func_sel_in    (in_code),
        .out_func_sel_in   (out_code),
        .cfg_in            (cfg),
        .ext_option_in     (ext_opt),
        .ext_pos_in        (ext_pos),
        .enc_pos_in        (enc_pos),
        .motor_speed_in    (mspeed),
        .run_speed_cmd_in  (run_cmd),
        .speed_cmd_out     (speed_cmd),
        .servo_lock_out    (lock),
        .pos_error_out     (pos_err),
        .gain_out          (gains),
        .orient_active_out (active),
        .orient_done_n_out (done_n)
    );

    shorc_motor_model motor (
        .sys_clk_in      (sys_clk_in),
        .sys_rst_in      (sys_rst_in),
        .speed_cmd_in    (speed_cmd),
        .motor_speed_out (mspeed),
        .enc_pos_out     (enc_pos)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic in_zone(input logic [11:0] pos,
        input logic [11:0] tgt, input logic [13:0] zone);
        logic [11:0] d;
        d = pos - tgt;
        if (d[11]) d = tgt - pos;
        return {2'b00, d} <= zone;
    endfunction

    // Shortest signed distance from shaft to target on one revolution
    function automatic logic [12:0] exp_err(input logic [11:0] tgt,
        input logic [11:0] pos);
        int e;
        e = int'(tgt) - int'(pos);
        if (e >= 2048) e -= 4096;
        if (e < -2048) e += 4096;
        return 13'(e);
    endfunction

    function automatic logic [11:0] exp_target(input shorc_cfg_t c,
        input logic opt, input logic [15:0] ep);
        logic [15:0] v;
        if (c.src_sel == SRC_SEL_INTERNAL) return c.target_pos[11:0];
        if (!opt || c.div_sel == 7'h00) return 12'h000;
        if (c.div_sel == 7'h01) begin
            if (c.src_sel == SRC_SEL_EXT6) return {ep[5:0], 6'h00};
            if (c.src_sel == SRC_SEL_EXT12) return ep[11:0];
            return ep[15:4];
        end
        v = (ep > {9'h000, c.div_sel}) ? {9'h000, c.div_sel} : ep;
        return 12'((32'(v) * 32'h1000) / (32'(c.div_sel) + 32'h1));
    endfunction

    // One orientation from running to lock, then release by a dropped level
    task automatic run_orient(input string name, input logic [11:0] tgt,
                              input logic via_start);
        int          n;
        logic        saw;
        logic [44:0] g;
        n = 0;
        saw = 1'b0;
        g = {(cfg.kp > KP_MAX) ? KP_MAX : cfg.kp, cfg.ti, cfg.kd,
             cfg.pos_gain};
        tick(3);
        req <= 1'b1;
        while (lock !== 1'b1 && n < 12000) begin
            tick(1);
            #1;
            if (speed_cmd === cfg.slow_speed) saw = 1'b1;
            n++;
        end
        if (n >= 12000) begin
            err_total++;
            $display("wrong value lock expected 1 seen timeout");
            give_verdict();
        end
        check("slowdown", 1, saw);
        check("active", 1, active);
        check("speed", 0, speed_cmd);
        check("zone", 1, in_zone(enc_pos, tgt, cfg.zone));
        check("gains", g, gains);
        tick(8);
        #1;
        check("done_n", (out_code === OUT_FUNC_DONE) ? 0 : 1, done_n);
        check("lock held", 1, lock);
        check("pos error", exp_err(tgt, enc_pos), pos_err);
        tick(1);
        if (via_start) start <= 1'b0;
        else req <= 1'b0;
        tick(2);
        #1;
        check("release", 3'b001, {lock, active, done_n});
        tick(1);
        start <= 1'b1;
        req <= 1'b0;
        tick(40);
        $display("test %s done", name);
    endtask

    initial begin
        seed = 9;
        err_total = 0;
        compares = 0;
        sys_rst_in = 1'b1;
        start = 1'b1;
        req = 1'b0;
        in_code = IN_FUNC_ORIENT;
        out_code = OUT_FUNC_DONE;
        cfg = '{src_sel: SRC_SEL_OFF, slow_speed: SLOW_SPD_DEF,
                target_pos: TARGET_DEF, zone: ZONE_DEF, div_sel: DIV_DEF,
                pos_gain: PGAIN_DEF, kp: KP_DEF, ti: TI_DEF, kd: KD_DEF};
        ext_opt = 1'b0;
        ext_pos = 16'h0000;
        run_cmd = 11'h300;
        tick(9);
        #1;
        check("reset outs", 3'b001, {lock, active, done_n});
        check("reset gains", {KP_DEF, TI_DEF, KD_DEF, PGAIN_DEF}, gains);
        tick(1);
        sys_rst_in <= 1'b0;
        // Disabled source, invalid source and wrong input code
        for (int k = 0; k < 3; k++) begin
            tick(1);
            cfg.src_sel <= (k == 0) ? SRC_SEL_OFF :
                           ((k == 1) ? 14'h0004 : SRC_SEL_INTERNAL);
            in_code <= (k == 2) ? 8'h15 : IN_FUNC_ORIENT;
            req <= 1'b1;
            tick(20);
            #1;
            check("ignored", 0, active);
            check("pass speed", run_cmd, speed_cmd);
            tick(1);
            req <= 1'b0;
        end
        $display("test refusals done");
        in_code <= IN_FUNC_ORIENT;
        for (int k = 0; k < 3; k++) begin
            tick(1);
            cfg.target_pos <= 14'($random(seed));
            cfg.slow_speed <= 11'h032 + 11'($random(seed) & 255);
            run_cmd <= 11'h190 + 11'($random(seed) & 511);
            cfg.kp <= (k == 1) ? 10'h3FF : 10'($random(seed) & 511);
            out_code <= (k == 2) ? 8'h1A : OUT_FUNC_DONE;
            tick(1);
            run_orient("internal", exp_target(cfg, ext_opt, ext_pos), k == 1);
        end
        for (int k = 0; k < 7; k++) begin
            tick(1);
            cfg.src_sel <= SRCS[k];
            cfg.div_sel <= DIVS[k];
            out_code <= OUT_FUNC_DONE;
            ext_opt <= (k != 0);
            ext_pos <= (k == 5) ? 16'h00C8 : 16'($random(seed));
            tick(1);
            run_orient("external", exp_target(cfg, ext_opt, ext_pos), 1'b0);
        end
        give_verdict();
    end
endmodule

// ===== hdl/shorc_cfg_check.sv
// Range checking and clamping of the orientation settings.
// Assumes settings are static levels from the external controller.
module shorc_cfg_check
    import shorc_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             sys_rst_in,
    input  wire shorc_pkg::shorc_cfg_t cfg_in,
    output shorc_pkg::shorc_cfg_t cfg_out,
    output logic                  enable_out
);
    shorc_cfg_t cfg_next;
    logic       src_ok;

    always_comb begin
        cfg_next = cfg_in;
        src_ok   = (cfg_in.src_sel <= SRC_SEL_EXT16);
        if (cfg_in.slow_speed > SLOW_SPD_MAX)                  // [RULE2]
            cfg_next.slow_speed = SLOW_SPD_MAX;
        if (cfg_in.target_pos > TARGET_MAX)                    // [RULE7]
            cfg_next.target_pos = TARGET_MAX;
        if (cfg_in.zone > ZONE_MAX)                            // [RULE4]
            cfg_next.zone = ZONE_MAX;
        if (cfg_in.div_sel > DIV_MAX)                          // [RULE8]
            cfg_next.div_sel = DIV_MAX;
        if (cfg_in.pos_gain < PGAIN_MIN)                       // [RULE9]
            cfg_next.pos_gain = PGAIN_MIN;
        else if (cfg_in.pos_gain > PGAIN_MAX)
            cfg_next.pos_gain = PGAIN_MAX;
        if (cfg_in.kp > KP_MAX)                                // [RULE10]
            cfg_next.kp = KP_MAX;
        if (cfg_in.ti > TI_MAX)                                // [RULE11]
            cfg_next.ti = TI_MAX;
        if (cfg_in.kd > KD_MAX)                                // [RULE12]
            cfg_next.kd = KD_MAX;
        if (!src_ok)                                           // [RULE1]
            cfg_next.src_sel = SRC_SEL_OFF;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cfg_out <= '{SRC_SEL_OFF, SLOW_SPD_DEF, TARGET_DEF, ZONE_DEF,
                         DIV_DEF, PGAIN_DEF, KP_DEF, TI_DEF, KD_DEF};
            enable_out <= 1'b0;
        end else begin
            cfg_out    <= cfg_next;
            enable_out <= src_ok;                              // [RULE1]
        end
    end

    property p_off_disables;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (cfg_in.src_sel == SRC_SEL_OFF) |=> !enable_out;
    endproperty
    a_off_disables: assert property (p_off_disables)           // [RULE1]
        else $error("orientation enabled with source off");
    property p_zone_clamp;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (cfg_in.zone > ZONE_MAX) |=> (cfg_out.zone == ZONE_MAX);
    endproperty
    a_zone_clamp: assert property (p_zone_clamp)               // [RULE4]
        else $error("zone not clamped");
    property p_pgain_min;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (cfg_in.pos_gain == 10'h000) |=> (cfg_out.pos_gain == PGAIN_MIN);
    endproperty
    a_pgain_min: assert property (p_pgain_min)                 // [RULE9]
        else $error("position gain below minimum");
endmodule

// ===== hdl/shorc_pkg.sv
// Constants, types and settings for the shaft orientation control block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
// Notes on behaviour
// [RULE1] Source select 0-3 or 9999; 9999 disables
// [RULE2] Request while running slows to switchover speed
// [RULE3] Compute distance, decelerate, then hold servo lock
// [RULE4] Done low when stopped inside zone, start+request
// [RULE5] Acts only while request held; input code 22
// [RULE6] Done output only when terminal code 27
// [RULE7] Internal target position 0 to 16383, default 0
// [RULE8] Divider select 0, 1, 2 to 127, default 0
// [RULE9] Position loop gain 0.1 to 100, default 10
// [RULE10] Speed P gain 0 to 1000 percent, default 60
// [RULE11] Integral time 0 to 20.0 s, default 0.333
// [RULE12] Speed D gain 0 to 100.0 percent, default 1
// [RULE13] Stop shaft at selected position using encoder
// [RULE14] One revolution resolves into 4096 addresses
// [RULE15] Source 0 uses internal target position
// [RULE16] No option or divider 0 gives position 0
// [RULE17] Release done and lock when start/request drop
package shorc_pkg;
    localparam logic [13:0] SRC_SEL_INTERNAL = 14'h0000;
    localparam logic [13:0] SRC_SEL_EXT6     = 14'h0001;
    localparam logic [13:0] SRC_SEL_EXT12    = 14'h0002;
    localparam logic [13:0] SRC_SEL_EXT16    = 14'h0003;
    localparam logic [13:0] SRC_SEL_OFF      = 14'h270F;
    localparam logic [10:0] SLOW_SPD_MAX     = 11'h3E8;
    localparam logic [10:0] SLOW_SPD_DEF     = 11'h0C8;
    localparam logic [13:0] TARGET_MAX       = 14'h3FFF;
    localparam logic [13:0] TARGET_DEF       = 14'h0000;
    localparam logic [13:0] ZONE_MAX         = 14'h2000;
    localparam logic [13:0] ZONE_DEF         = 14'h000B;
    localparam logic [6:0]  DIV_MAX          = 7'h7F;
    localparam logic [6:0]  DIV_DEF          = 7'h00;
    // Position gain in tenths: 0.1 to 100
    localparam logic [9:0]  PGAIN_MIN        = 10'h001;
    localparam logic [9:0]  PGAIN_MAX        = 10'h3E8;
    localparam logic [9:0]  PGAIN_DEF        = 10'h064;
    localparam logic [9:0]  KP_MAX           = 10'h3E8;
    localparam logic [9:0]  KP_DEF           = 10'h03C;
    // Integral time in milliseconds
    localparam logic [14:0] TI_MAX           = 15'h4E20;
    localparam logic [14:0] TI_DEF           = 15'h014D;
    // Derivative gain in tenths of a percent
    localparam logic [9:0]  KD_MAX           = 10'h3E8;
    localparam logic [9:0]  KD_DEF           = 10'h00A;
    localparam logic [7:0]  IN_FUNC_ORIENT   = 8'h16;
    localparam logic [7:0]  OUT_FUNC_DONE    = 8'h1B;
    localparam logic [12:0] POS_PER_REV      = 13'h1000;
    localparam logic [10:0] SPEED_STEP       = 11'h001;
    localparam logic [10:0] APPROACH_SPD     = 11'h00A;

    typedef enum {ST_IDLE, ST_SLOW, ST_CALC, ST_APPROACH, ST_LOCK}
        shorc_state_t;

    typedef struct packed {
        logic [13:0] src_sel;
        logic [10:0] slow_speed;
        logic [13:0] target_pos;
        logic [13:0] zone;
        logic [6:0]  div_sel;
        logic [9:0]  pos_gain;
        logic [9:0]  kp;
        logic [14:0] ti;
        logic [9:0]  kd;
    } shorc_cfg_t;

    typedef struct packed {
        logic [9:0]  kp;
        logic [14:0] ti;
        logic [9:0]  kd;
        logic [9:0]  pos_gain;
    } shorc_gain_t;
endpackage

// ===== hdl/shorc_target_sel.sv
// Stop position selection from internal setting or external command.
// Assumes external data is stable while orientation runs.
module shorc_target_sel
    import shorc_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              load_in,
    input  wire shorc_pkg::shorc_cfg_t cfg_in,
    input  wire logic              ext_option_in,
    input  wire logic [15:0]       ext_pos_in,
    output logic [11:0]            target_out
);
    logic [11:0] target_next;
    logic [15:0] cmd;
    logic [7:0]  steps;
    logic [27:0] prod;

    always_comb begin
        cmd  = ext_pos_in;
        prod = 28'h0000000;
        steps = {1'b0, cfg_in.div_sel} + 8'h01;
        case (cfg_in.src_sel)
            SRC_SEL_EXT6:  cmd = {10'h000, ext_pos_in[5:0]};
            SRC_SEL_EXT12: cmd = {4'h0, ext_pos_in[11:0]};
            default:       cmd = ext_pos_in;
        endcase
        if (cfg_in.src_sel == SRC_SEL_INTERNAL) begin
            // Addresses wrap at one revolution
            target_next = cfg_in.target_pos[11:0];            // [RULE15] [RULE14]
        end else if (!ext_option_in || cfg_in.div_sel == 7'h00) begin
            target_next = 12'h000;                            // [RULE16]
        end else if (cfg_in.div_sel == 7'h01) begin
            // Scale the command width to 12 address bits; 16-bit drops its low 4 bits
            case (cfg_in.src_sel)
                SRC_SEL_EXT6:  target_next = {cmd[5:0], 6'h00};
                SRC_SEL_EXT12: target_next = cmd[11:0];
                default:       target_next = cmd[15:4];
            endcase
        end else begin
            if (cmd > {8'h00, cfg_in.div_sel})
                cmd = {9'h000, cfg_in.div_sel};
            prod = 28'(cmd) * 28'(POS_PER_REV);
            target_next = 12'(prod / 28'(steps));             // [RULE8]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            target_out <= 12'h000;
        else if (load_in)
            target_out <= target_next;
    end

    property p_no_option;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (load_in && !ext_option_in && cfg_in.src_sel != SRC_SEL_INTERNAL)
        |=> (target_out == 12'h000);
    endproperty
    a_no_option: assert property (p_no_option)                // [RULE16]
        else $error("external source without option not zero");
    property p_internal;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (load_in && cfg_in.src_sel == SRC_SEL_INTERNAL)
        |=> (target_out == $past(cfg_in.target_pos[11:0]));
    endproperty
    a_internal: assert property (p_internal)                  // [RULE15]
        else $error("internal target not used");
endmodule

// ===== hdl/shorc_top.sv
// Orientation sequencer: slowdown, approach, servo lock and done output.
// Assumes request and start are synchronous levels; encoder gives
// a 12-bit shaft address and speed feedback in r/min.
module shorc_top
    import shorc_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic               start_in,
    input  wire logic               orient_request_in,
    input  wire logic [7:0]         in_func_sel_in,
    input  wire logic [7:0]         out_func_sel_in,
    input  wire shorc_pkg::shorc_cfg_t cfg_in,
    input  wire logic               ext_option_in,
    input  wire logic [15:0]        ext_pos_in,
    input  wire logic [11:0]        enc_pos_in,
    input  wire logic [10:0]        motor_speed_in,
    input  wire logic [10:0]        run_speed_cmd_in,
    output logic [10:0]             speed_cmd_out,
    output logic                    servo_lock_out,
    output logic signed [12:0]      pos_error_out,
    output shorc_pkg::shorc_gain_t  gain_out,
    output logic                    orient_active_out,
    output logic                    orient_done_n_out
);
    import shorc_pkg::*;

    shorc_cfg_t   cfg;
    logic         enable;
    logic [11:0]  target;
    shorc_state_t state_reg;
    shorc_state_t state_next;
    logic         load;
    logic         hold;
    logic         running;
    logic [10:0]  speed_next;
    logic signed [12:0] err;
    logic [11:0]  dist_reg;
    logic [12:0]  abs_err;
    logic         in_zone;
    logic         done_next;

    // Wrap-around shortest signed distance on the 4096-address circle
    function automatic logic signed [12:0] wrap_err(
        input logic [11:0] tgt,
        input logic [11:0] pos
    );
        logic [11:0] d;
        d = tgt - pos;
        wrap_err = {d[11], d};
    endfunction

    shorc_cfg_check u_cfg (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .cfg_in     (cfg_in),
        .cfg_out    (cfg),
        .enable_out (enable)
    );

    shorc_target_sel u_tgt (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .load_in       (load),
        .cfg_in        (cfg),
        .ext_option_in (ext_option_in),
        .ext_pos_in    (ext_pos_in),
        .target_out    (target)
    );

    // Request counts only when mapped to an input terminal
    assign hold = enable && orient_request_in
                  && (in_func_sel_in == IN_FUNC_ORIENT);       // [RULE5]
    assign running = start_in && (motor_speed_in != 11'h000);
    assign load = (state_reg == ST_IDLE) && hold && running;
    assign err = wrap_err(target, enc_pos_in);                 // [RULE13]
    assign abs_err = err[12] ? 13'(-err) : 13'(err);
    assign in_zone = ({1'b0, abs_err} <= cfg.zone)
                     || (cfg.zone >= ZONE_MAX);              // [RULE4]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (load)
                    state_next = ST_SLOW;                      // [RULE2]
            ST_SLOW:
                if (motor_speed_in <= cfg.slow_speed)
                    state_next = ST_CALC;                      // [RULE3]
            ST_CALC:
                state_next = ST_APPROACH;                      // [RULE3]
            ST_APPROACH:
                if (in_zone && motor_speed_in == 11'h000)
                    state_next = ST_LOCK;                      // [RULE3]
            ST_LOCK:
                state_next = ST_LOCK;
            default:
                state_next = ST_IDLE;
        endcase
        if (!hold || !start_in)
            state_next = ST_IDLE;                              // [RULE5] [RULE17]
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Remaining distance latched once at switchover
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            dist_reg <= 12'h000;
        else if (state_reg == ST_CALC)
            dist_reg <= abs_err[11:0];                         // [RULE3]
    end

    always_comb begin
        speed_next = run_speed_cmd_in;
        case (state_reg)
            ST_SLOW: begin
                if (speed_cmd_out > cfg.slow_speed + SPEED_STEP)
                    speed_next = speed_cmd_out - SPEED_STEP;  // [RULE2]
                else
                    speed_next = cfg.slow_speed;
            end
            ST_CALC:
                speed_next = cfg.slow_speed;
            ST_APPROACH: begin
                // Taper speed with remaining distance
                if (abs_err > 13'(cfg.slow_speed))
                    speed_next = cfg.slow_speed;
                else if (abs_err > 13'(APPROACH_SPD))
                    speed_next = 11'(abs_err);                 // [RULE3]
                else
                    speed_next = in_zone ? 11'h000 : APPROACH_SPD;
            end
            ST_LOCK:
                speed_next = 11'h000;
            default:
                speed_next = run_speed_cmd_in;
        endcase
        if (state_next == ST_IDLE)
            speed_next = run_speed_cmd_in;
        else if (state_next == ST_LOCK)
            speed_next = 11'h000;                              // [RULE3]
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            speed_cmd_out <= 11'h000;
        else
            speed_cmd_out <= speed_next;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            servo_lock_out    <= 1'b0;
            orient_active_out <= 1'b0;
            pos_error_out     <= 13'sh0000;
        end else begin
            servo_lock_out    <= (state_next == ST_LOCK);      // [RULE3] [RULE17]
            orient_active_out <= (state_next != ST_IDLE);
            pos_error_out     <= err;
        end
    end

    // Orientation gains follow the clamped settings in every state
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            gain_out <= '{KP_DEF, TI_DEF, KD_DEF, PGAIN_DEF};
        end else begin
            gain_out.kp       <= cfg.kp;                       // [RULE10]
            gain_out.ti       <= cfg.ti;                       // [RULE11]
            gain_out.kd       <= cfg.kd;                       // [RULE12]
            gain_out.pos_gain <= cfg.pos_gain;                 // [RULE9]
        end
    end

    assign done_next = (state_next == ST_LOCK) && in_zone && start_in
                       && hold && (out_func_sel_in == OUT_FUNC_DONE);

    // Active low; high when released
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            orient_done_n_out <= 1'b1;
        else
            orient_done_n_out <= !done_next;                   // [RULE4] [RULE6]
    end

    property p_done_cause;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !orient_done_n_out |-> (state_reg == ST_LOCK) && $past(start_in)
        && ($past(out_func_sel_in) == OUT_FUNC_DONE);
    endproperty
    a_done_cause: assert property (p_done_cause)               // [RULE4]
        else $error("done asserted outside lock");
    property p_done_code;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (out_func_sel_in != OUT_FUNC_DONE) |=> orient_done_n_out;
    endproperty
    a_done_code: assert property (p_done_code)                 // [RULE6]
        else $error("done asserted without output code");
    property p_release;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (!start_in || !orient_request_in) |=>
        orient_done_n_out && !servo_lock_out;
    endproperty
    a_release: assert property (p_release)                     // [RULE17]
        else $error("done or lock not released");
    property p_need_code;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (in_func_sel_in != IN_FUNC_ORIENT) |=> !orient_active_out;
    endproperty
    a_need_code: assert property (p_need_code)                 // [RULE5]
        else $error("orientation without input code");
    property p_slow_start;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (load && !$past(load)) |=> orient_active_out;
    endproperty
    a_slow_start: assert property (p_slow_start)               // [RULE2]
        else $error("request while running not taken");
    property p_lock_zero;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        servo_lock_out |-> (speed_cmd_out == 11'h000);
    endproperty
    a_lock_zero: assert property (p_lock_zero)                 // [RULE3]
        else $error("speed nonzero in servo lock");
endmodule
